// ---- common/mgmt_link_if.sv ----
`timescale 1ns/1ps
`include "mgmt_link_params.svh"
interface mgmt_link_if #(
    parameter int LANES = `MGMT_LANES,
    parameter int AW    = `MGMT_ADDR_BASE_W + $clog2(LANES)
);
    logic [AW-1:0]               csr_addr;        // word address
    logic [`MGMT_DATA_W-1:0]     csr_write_word;  // write data
    logic [`MGMT_DATA_W-1:0]     csr_read_word;   // read data
    logic                        csr_write;       // write strobe
    logic                        csr_read;        // read strobe
    logic                        csr_wait;        // wait request
    logic [LANES-1:0]            tx_serial;       // serial data device to far side
    logic [LANES-1:0]            rx_serial;       // serial data far side to device
    logic [LANES-1:0]            tx_serial_clk;   // per-lane serial clocks
    logic                        tx_pll_lock;     // and-combined pll lock
    logic                        core_reset;      // core reset, active high
    logic                        ref_clk;         // unused reference clock
    logic                        xfer_clk_in;     // transfer clock, advanced mode
    logic                        xfer_clk_out;    // transfer clock, standard mode
    modport device (
        input  csr_addr, csr_write_word, csr_write, csr_read, rx_serial,
        input  tx_serial_clk, tx_pll_lock, core_reset, ref_clk, xfer_clk_in,
        output csr_read_word, csr_wait, tx_serial, xfer_clk_out
    );
    modport host (
        output csr_addr, csr_write_word, csr_write, csr_read, rx_serial,
        output tx_serial_clk, tx_pll_lock, core_reset, ref_clk, xfer_clk_in,
        input  csr_read_word, csr_wait, tx_serial, xfer_clk_out
    );
endinterface

// ---- common/mgmt_link_params.svh ----
`ifndef MGMT_LINK_PARAMS_SVH
`define MGMT_LINK_PARAMS_SVH

// management port word width
`define MGMT_DATA_W 32
// base address bits before the per-lane extension
`define MGMT_ADDR_BASE_W 11
// default lane count
`define MGMT_LANES 4
// cycles of wait request before a read answer
`define MGMT_RD_WAIT 2
// cycles of wait request before a write completes
`define MGMT_WR_WAIT 1
// reset value of every storage word
`define MGMT_WORD_RST 32'h0000_0000
// management clock range limits in hertz
`define MGMT_CLK_MIN_HZ 100
`define MGMT_CLK_MAX_HZ 150000000
// management clock divider for the standard-mode transfer clock (half period)
`define XFER_CLK_HALF 2

`endif

// ---- common/mgmt_link_pkg.sv ----
package mgmt_link_pkg;
    // clocking mode of the transfer clock
    typedef enum logic [1:0]
    {
        CLK_STANDARD = 2'h1,
        CLK_ADVANCED = 2'h2
    } clk_mode_e;
endpackage

// ---- rtl/mgmt_link_device.sv ----
`timescale 1ns/1ps
`include "mgmt_link_params.svh"
// Contract
// R1: management clock runs port and reset sequencer
// R2: management clock stays 100 Hz to 150 MHz (the testbench runs it at 200 MHz)
// R3: global reset high resets whole core
// R4: address is 11 plus log2 lanes bits
// R5: write strobe high with 32-bit word
// R6: read strobe returns addressed 32-bit word
// R7: wait request while request cannot complete
// R8: master holds request until wait drops
// R9: one serial out and in per lane
// R10: one serial clock per transmit lane
// R11: pll locks anded into single input
// R12: core reset async, spares fractional_pll state
// R13: core reset tied to global reset (here the host drives core reset from its own core_reset_i input)
// R14: reference clock tied to zero
// R15: transfer clock input advanced, output standard
module mgmt_link_device
    import mgmt_link_pkg::*;
#(
    parameter int        LANES    = `MGMT_LANES,
    parameter clk_mode_e CLK_MODE = CLK_STANDARD,
    parameter int        AW       = `MGMT_ADDR_BASE_W + $clog2(LANES),
    parameter int        DEPTH    = 16
)(
    input  wire logic    mclk_i,       // management clock
    input  wire logic    rst_n_i,      // async active-low power-on reset
    input  wire logic    mgmt_reset_i, // global reset, active high level
    mgmt_link_if.device  link,
    output logic         link_up_o,    // core out of reset and pll locked
    output logic         pll_ready_o   // fractional_pll sequence complete
);
    // storage words are picked by the low address bits only
    localparam int IW = $clog2(DEPTH);

    // management slave phases, one-hot; wait request is high in every phase
    // but the answer cycle, so the take edge can never look like a completion
    // limitation: one access at a time, no pipelining of requests
    typedef enum logic [2:0]
    {
        SL_IDLE  = 3'h1,  // no access, waiting for a strobe
        SL_STALL = 3'h2,  // access taken, counting down the wait cycles
        SL_CLOSE = 3'h4   // answer given, master drops its strobe here
    } slave_e;

    // whole state in one struct, storage included, so one register
    // process and one next-state process cover everything but core_rst_q
    typedef struct packed {
        logic [DEPTH-1:0][`MGMT_DATA_W-1:0] mem;   // csr storage
        logic [`MGMT_DATA_W-1:0]            rdata; // read answer
        logic                               wait_r;// wait request
        logic [1:0]                         cnt;   // wait countdown
        slave_e                             phase; // management slave phase
        logic [LANES-1:0]                   tx;    // serial out
        logic                               pll_ok;// fractional_pll ready
        logic                               up;    // link layer up
        logic [1:0]                         div;   // transfer clock divider
        logic                               xclk;  // generated transfer clock
    } st_s;

    // state after either reset: port stalled and idle, storage and pll state cleared
    localparam st_s RST_S = '{phase: SL_IDLE, wait_r: 1'b1, default: '0};

    // registered state and its next value
    st_s s_q;
    st_s s_d;
    logic core_rst_q;  // link layer reset, async set from core reset

    // low bits of the word address pick the storage word
    // aliasing is deliberate: high address bits are ignored, so software
    // sees the storage repeat through the whole address space
    function automatic logic [IW-1:0] word_sel(input logic [AW-1:0] a);
        word_sel = a[IW-1:0];
    endfunction

    // core reset is asynchronous; release is synchronised to mclk
    // only the link layer listens to it: storage, port and the fractional_pll
    // sequencer keep running, so software can still read status meanwhile
    always_ff @(posedge mclk_i or negedge rst_n_i or posedge link.core_reset)
    begin
        if (!rst_n_i)
        begin
            // power-on reset holds the link layer down as well
            core_rst_q <= 1'b1;
        end
        else if (link.core_reset)
        begin
            core_rst_q <= 1'b1; // R12
        end
        else
        begin
            // release one edge after the pin drops, never mid-cycle
            core_rst_q <= 1'b0;
        end
    end

    // next-state logic for the port, sequencer and serial path
    always_comb
    begin
        s_d = s_q;
        // every field holds unless a branch below moves it
        // fractional_pll sequencer stepped by mclk, only global and power-on reset touch it
        // a lock that drops is followed at once, the sequencer restarts from it
        s_d.pll_ok = link.tx_pll_lock; // R1 R11
        // link layer comes up once core reset gone and lock present
        // lock loss takes the link down again two edges later
        s_d.up = !core_rst_q && s_q.pll_ok;
        // per-lane loopback of received bits keeps each lane live
        // it stands in for the lane serialiser and drops to zero in core reset
        s_d.tx = core_rst_q ? '0 : link.rx_serial; // R9 R10 R12
        // divider generates the transfer clock in standard mode only
        // in advanced mode the user supplies that clock, so the output stays low
        if (CLK_MODE == CLK_STANDARD) // R15
        begin
            if (s_q.div == 2'(`XFER_CLK_HALF - 1))
            begin
                // half period reached: flip and restart
                s_d.div  = 2'h0;
                s_d.xclk = !s_q.xclk;
            end
            else
            begin
                // keep counting toward the half period
                s_d.div = s_q.div + 2'h1;
            end
        end
        // management slave: wait request stays high except in the single answer
        // cycle; a master holding its strobe until wait drops then sees exactly one
        // completion per access
        case (s_q.phase)
            SL_IDLE:
            begin
                // take a request on the first edge its strobe is seen
                if (link.csr_read || link.csr_write) // R5 R6
                begin
                    s_d.phase  = SL_STALL;
                    s_d.wait_r = 1'b1; // R7
                    s_d.cnt    = link.csr_read ? 2'(`MGMT_RD_WAIT) : 2'(`MGMT_WR_WAIT);
                end
            end
            SL_STALL:
            begin
                s_d.cnt = s_q.cnt - 2'h1;
                // request held stable by the master, so act at the final count;
                // a zero count acts at once rather than wrapping round
                if (s_q.cnt <= 2'h1) // R8
                begin
                    s_d.cnt    = 2'h0;
                    s_d.phase  = SL_CLOSE;
                    s_d.wait_r = 1'b0; // R7
                    if (link.csr_write)
                    begin
                        s_d.mem[word_sel(link.csr_addr)] = link.csr_write_word; // R4
                    end
                    else
                    begin
                        // read word stands until the next read answers
                        s_d.rdata = s_q.mem[word_sel(link.csr_addr)]; // R6
                    end
                end
            end
            SL_CLOSE:
            begin
                // the master lowers its strobe at this edge, so the strobe still
                // seen here belongs to the finished access and is not taken again
                s_d.phase  = SL_IDLE;
                s_d.wait_r = 1'b1; // R7
            end
            default:
            begin
                // an illegal code recovers to idle with the port stalled
                s_d.phase  = SL_IDLE;
                s_d.wait_r = 1'b1;
            end
        endcase
    end

    // global reset clears everything, the fractional_pll included; it is
    // synchronous, so a glitch between edges cannot tear the storage
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= RST_S;
        end
        else if (mgmt_reset_i)
        begin
            // level sensitive: the whole core is held for as long as it stands
            s_q <= RST_S; // R3
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    // the answer, wait request and lanes all leave from registers, which costs
    // a cycle of latency but keeps the far side free of glitches
    assign link.csr_read_word = s_q.rdata;
    assign link.csr_wait      = s_q.wait_r;
    assign link.tx_serial     = s_q.tx;
    assign link.xfer_clk_out  = s_q.xclk;
    assign link_up_o          = s_q.up;
    assign pll_ready_o        = s_q.pll_ok;
endmodule

// ---- rtl/mgmt_link_host.sv ----
`timescale 1ns/1ps
`include "mgmt_link_params.svh"
module mgmt_link_host
    import mgmt_link_pkg::*;
#(
    parameter int        LANES    = `MGMT_LANES,
    parameter clk_mode_e CLK_MODE = CLK_STANDARD,
    parameter int        AW       = `MGMT_ADDR_BASE_W + $clog2(LANES)
)(
    input  wire logic                    mclk_i,      // management clock
    input  wire logic                    rst_n_i,     // async active-low reset
    mgmt_link_if.host                    link,
    input  wire logic                    req_i,       // start one access, pulse
    input  wire logic                    we_i,        // 1 write, 0 read
    input  wire logic [AW-1:0]           addr_i,      // word address
    input  wire logic [`MGMT_DATA_W-1:0] wdata_i,     // write word
    input  wire logic [LANES-1:0]        pll_lock_i,  // per-pll lock bits
    input  wire logic [LANES-1:0]        serial_clk_i,// per-lane serial clocks
    input  wire logic [LANES-1:0]        rx_serial_i, // serial bits toward device
    input  wire logic                    xfer_clk_i,  // user transfer clock
    input  wire logic                    core_reset_i,// requested core reset
    output logic                         busy_o,      // access outstanding
    output logic                         done_o,      // access complete pulse
    output logic [`MGMT_DATA_W-1:0]      rdata_o      // read result
);
    typedef struct packed {
        logic [AW-1:0]           addr;
        logic [`MGMT_DATA_W-1:0] wdata;
        logic                    wr;
        logic                    rd;
        logic                    done;
        logic [`MGMT_DATA_W-1:0] rdata;
        logic                    lock;
    } st_s;

    st_s s_q;
    st_s s_d;

    // next state: hold request until wait drops
    always_comb
    begin
        s_d      = s_q;
        s_d.done = 1'b0;
        s_d.lock = &pll_lock_i; // R11
        if (s_q.wr || s_q.rd)
        begin
            if (!link.csr_wait) // R8
            begin
                s_d.wr   = 1'b0;
                s_d.rd   = 1'b0;
                s_d.done = 1'b1;
                if (s_q.rd)
                begin
                    s_d.rdata = link.csr_read_word; // R6
                end
            end
        end
        else if (req_i)
        begin
            s_d.addr  = addr_i;
            s_d.wdata = wdata_i; // R5
            s_d.wr    = we_i;
            s_d.rd    = !we_i;
        end
    end

    // registered state
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign link.csr_addr       = s_q.addr;
    assign link.csr_write_word = s_q.wdata;
    assign link.csr_write      = s_q.wr;
    assign link.csr_read       = s_q.rd;
    assign link.tx_pll_lock    = s_q.lock;
    assign link.tx_serial_clk  = serial_clk_i;  // R10
    assign link.rx_serial      = rx_serial_i;
    assign link.core_reset     = core_reset_i;  // R13
    assign link.ref_clk        = 1'b0;          // R14
    assign link.xfer_clk_in    = (CLK_MODE == CLK_ADVANCED) ? xfer_clk_i : 1'b0; // R15
    assign busy_o              = s_q.wr || s_q.rd;
    assign done_o              = s_q.done;
    assign rdata_o             = s_q.rdata;
endmodule

// ---- tb/mgmt_link_sva.sv ----
`timescale 1ns/1ps
// watches the management port and pins between the two ends
module mgmt_link_sva #(
    parameter int LANES = 4,
    parameter int AW    = 13
)(
    input wire logic             mclk_i,
    input wire logic             rst_n_i,
    input wire logic [AW-1:0]    csr_addr,
    input wire logic [31:0]      csr_write_word,
    input wire logic             csr_write,
    input wire logic             csr_read,
    input wire logic             csr_wait,
    input wire logic [LANES-1:0] tx_serial,
    input wire logic             ref_clk,
    input wire logic             core_reset
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // a fresh read: the strobe has just come up
    sequence s_rd_take;
        $rose(csr_read);
    endsequence
    // wait stands at the take edge and two more, then the answer
    sequence s_rd_wait;
        csr_wait [*3] ##1 !csr_wait;
    endsequence
    // a fresh write: the strobe has just come up
    sequence s_wr_take;
        $rose(csr_write);
    endsequence
    // wait stands at the take edge and one more, then the write lands
    sequence s_wr_wait;
        csr_wait [*2] ##1 !csr_wait;
    endsequence
    a_rd_wait_two: assert property (s_rd_take |-> s_rd_wait)
        else $error("read stall length wrong");
    a_wr_wait_one: assert property (s_wr_take |-> s_wr_wait)
        else $error("write stall length wrong");
    a_answer_once: assert property (!csr_wait |=> csr_wait)
        else $error("wait request low for more than one cycle");
    a_addr_held: assert property ((csr_read || csr_write) && csr_wait |=> $stable(csr_addr))
        else $error("address moved while stalled");
    a_strobe_held: assert property (csr_wait && csr_read |=> csr_read)
        else $error("read strobe dropped while stalled");
    a_wr_held: assert property (csr_wait && csr_write |=> csr_write)
        else $error("write strobe dropped while stalled");
    a_word_held: assert property (csr_wait && csr_write |=> $stable(csr_write_word))
        else $error("write word moved while stalled");
    a_one_strobe: assert property (!(csr_read && csr_write))
        else $error("both strobes high");
    a_ref_zero: assert property (ref_clk == 1'b0)
        else $error("reference clock not tied low");
    a_core_quiet: assert property (core_reset |=> tx_serial == '0)
        else $error("serial out active in core reset");
endmodule

// ---- tb/serial_link_mgmt_clock_reset_port_test.sv ----
`timescale 1ns/1ps
module serial_link_mgmt_clock_reset_port_test;
    logic        mclk, rst_n, mgmt_reset, req, we, core_reset, xfer_clk, xp;
    logic [12:0] addr;          // 11 + log2 of four lanes
    logic [31:0] wdata, rdata;
    logic [3:0]  lock, sclk, rxs;
    logic        busy, done, link_up, pll_ready;
    logic [31:0] mem [16];      // model of storage, low four bits alias
    int          fail_count, check_count, i, n;
    mgmt_link_if link_bus ();
    mgmt_link_device i_mgmt_link_device (.mclk_i(mclk), .rst_n_i(rst_n), .mgmt_reset_i(mgmt_reset),
        .link(link_bus), .link_up_o(link_up), .pll_ready_o(pll_ready));
    mgmt_link_host i_mgmt_link_host (.mclk_i(mclk), .rst_n_i(rst_n), .link(link_bus), .req_i(req),
        .we_i(we), .addr_i(addr), .wdata_i(wdata), .pll_lock_i(lock), .serial_clk_i(sclk),
        .rx_serial_i(rxs), .xfer_clk_i(xfer_clk), .core_reset_i(core_reset), .busy_o(busy),
        .done_o(done), .rdata_o(rdata));
    mgmt_link_sva i_mgmt_link_sva (.mclk_i(mclk), .rst_n_i(rst_n), .csr_addr(link_bus.csr_addr),
        .csr_write_word(link_bus.csr_write_word), .csr_write(link_bus.csr_write),
        .csr_read(link_bus.csr_read), .csr_wait(link_bus.csr_wait), .tx_serial(link_bus.tx_serial),
        .ref_clk(link_bus.ref_clk), .core_reset(link_bus.core_reset));
    // 200 MHz management clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // inputs move 1 ns after the edge
    task step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // one access through the host; reads compared with the model
    task acc(input logic w, input logic [12:0] a, input logic [31:0] d);
        int j;
        for (j = 0; j < 20 && busy !== 1'b0; j++) step(1);
        if (busy !== 1'b0)
        begin
            fail_count++;
            conclude();
        end
        req = 1'b1;
        we = w;
        addr = a;
        wdata = d;
        step(1);
        req = 1'b0;
        for (j = 0; j < 20 && done !== 1'b1; j++) step(1);
        if (done !== 1'b1)
        begin
            fail_count++;
            conclude();
        end
        if (w)
            mem[a[3:0]] = d;
        else
            chk(rdata, mem[a[3:0]]);
    endtask
    initial
    begin
        rst_n = 1'b0; mgmt_reset = 1'b0; req = 1'b0; we = 1'b0; addr = 13'h0000; wdata = 32'h0;
        lock = 4'hf; sclk = 4'h0; rxs = 4'h0; xfer_clk = 1'b0; core_reset = 1'b0;
        fail_count = 0; check_count = 0;
        for (i = 0; i < 16; i++) mem[i] = 32'h0;
        step(10);
        rst_n = 1'b1;
        void'($urandom(21));
        for (i = 0; i < 16; i++) acc(1'b0, 13'(i), 32'h0);
        $display("test reset values done");
        // random traffic, high address bits alias onto the same words
        for (i = 0; i < 40; i++) acc(1'($urandom), 13'($urandom), $urandom);
        $display("test traffic done");
        // global reset, core reset tied to it, stalls the port and clears storage
        rxs = 4'h6;
        step(1);
        chk(link_bus.tx_serial, 4'h6);
        mgmt_reset = 1'b1;
        core_reset = 1'b1;
        step(2);
        chk(link_bus.csr_wait, 1'b1);
        chk(pll_ready, 1'b0);
        chk(link_up, 1'b0);
        chk(link_bus.tx_serial, 4'h0);
        mgmt_reset = 1'b0;
        core_reset = 1'b0;
        step(1);
        for (i = 0; i < 16; i++) mem[i] = 32'h0;
        for (i = 0; i < 16; i++) acc(1'b0, 13'(i + 16), 32'h0);
        $display("test global reset done");
        // core reset quiets the link yet keeps storage and pll state
        acc(1'b1, 13'h1a5, 32'hdead_beef);
        core_reset = 1'b1;
        step(2);
        chk(link_up, 1'b0);
        chk(pll_ready, 1'b1);
        chk(link_bus.tx_serial, 4'h0);
        core_reset = 1'b0;
        for (i = 0; i < 8 && link_up !== 1'b1; i++) step(1);
        chk(link_up, 1'b1);
        acc(1'b0, 13'h0005, 32'h0);
        $display("test core reset done");
        // per-lane pins and the combined lock
        for (i = 0; i < 8; i++)
        begin
            lock = 4'($urandom);
            sclk = 4'($urandom);
            rxs = 4'($urandom);
            xfer_clk = 1'($urandom);
            step(2);
            chk(link_bus.tx_pll_lock, &lock);
            chk(pll_ready, &lock);
            chk(link_bus.tx_serial_clk, sclk);
            chk(link_bus.rx_serial, rxs);
            chk(link_bus.tx_serial, rxs);
            chk(link_bus.ref_clk, 1'b0);
            chk(link_bus.xfer_clk_in, 1'b0);
        end
        lock = 4'hf;
        $display("test lanes done");
        // standard mode transfer clock is a quarter of the management clock
        n = 0;
        for (i = 0; i < 16; i++)
        begin
            xp = link_bus.xfer_clk_out;
            step(1);
            if (link_bus.xfer_clk_out !== xp)
                n++;
        end
        chk(n, 8);
        $display("test transfer clock done");
        conclude();
    end
endmodule
